// ---- design/mpc_chan_pwm.sv ----
// One PWM channel: holds the applied duty and compares it to the position.
// Assumes pos, frame_idx and start come from the shared counter on clk.
`timescale 1ns/1ps
`default_nettype none
module mpc_chan_pwm (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Channel control
    input  wire logic       enable,
    input  wire logic [7:0] target,
    input  wire logic       skip_en,
    // Timing from the shared counter
    input  wire logic [2:0] frame_idx,
    input  wire logic [7:0] pos,
    input  wire logic       start,
    // Result
    output logic            pwm_out
);
    logic [7:0] active;
    logic       running;
    logic [7:0] next_active;
    logic       next_running;

    // ------------------------------------------------------------
    // Applied duty
    // ------------------------------------------------------------
    always_comb begin
        next_active  = active;
        next_running = running;
        if (!enable) begin
            next_running = 1'b0;
        end else if (target == mpc_pkg::DUTY_FULL) begin
            next_active  = mpc_pkg::DUTY_FULL;
            next_running = 1'b1;
        end else if (start) begin
            next_active  = skip_en ? mpc_pkg::mpc_skip_code(target, frame_idx) : target;
            next_running = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active  <= 8'h00;
            running <= 1'b0;
        end else begin
            active  <= next_active;
            running <= next_running;
        end
    end

    assign pwm_out = enable & running & (pos <= active);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_sync_hold;
        @(posedge clk) disable iff (rst)
        (enable && target != mpc_pkg::DUTY_FULL && !start) |=> active == $past(active);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("duty changed mid period");

    property p_full_now;
        @(posedge clk) disable iff (rst)
        (enable && target == mpc_pkg::DUTY_FULL) |=> (active == 8'hff && running);
    endproperty
    a_full_now: assert property (p_full_now) else $error("full duty not immediate");

    property p_skip_fe;
        @(posedge clk) disable iff (rst)
        (enable && skip_en && start && target == 8'hfe && frame_idx == 3'd0)
            |=> active == 8'hf7;
    endproperty
    a_skip_fe: assert property (p_skip_fe) else $error("skip slot S0 missing");

    property p_low_plain;
        @(posedge clk) disable iff (rst)
        (enable && start && target <= 8'h07) |=> active == $past(target);
    endproperty
    a_low_plain: assert property (p_low_plain) else $error("low code altered");

endmodule : mpc_chan_pwm
`default_nettype wire

// ---- design/mpc_pkg.sv ----
// Constants, field layouts and carrier types of the multichannel PWM controller.
// Assumes a 25 MHz system clock; every pin arrives asynchronous to it.
package mpc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 25_000_000;
    localparam int REF_FMAX_HZ_X10 = 1_024_000;   // 102,4 kHz
    localparam int REF_FMIN_HZ_X10 = 256_000;     // 25,6 kHz
    localparam int REF_MIN_PER_CYC = (CLK_HZ * 10) / REF_FMAX_HZ_X10;
    localparam int REF_MAX_PER_CYC = (CLK_HZ * 10 + REF_FMIN_HZ_X10 - 1) / REF_FMIN_HZ_X10;
    // Generous margins so a jittery but legal reference never trips
    localparam int REF_FAST_CYC    = REF_MIN_PER_CYC / 2;
    localparam int REF_SLOW_CYC    = REF_MAX_PER_CYC * 2;

    // ------------------------------------------------------------
    // Frame layout and addresses
    // ------------------------------------------------------------
    localparam int       FRAME_BITS   = 16;
    localparam int       ADDR_LSB     = 12;
    localparam int       SUBSEL_BIT   = 11;
    localparam int       SYNC_BIT     = 1;
    localparam int       SKIP_LSB     = 6;
    localparam int       SIGN_BIT     = 10;
    localparam logic [3:0] ADDR_INIT2  = 4'h1;
    localparam logic [3:0] ADDR_CH_LO  = 4'h2;
    localparam logic [3:0] ADDR_CH_HI  = 4'h7;
    localparam logic [3:0] ADDR_OUTCTL = 4'h8;
    localparam logic [3:0] ADDR_GLOBAL = 4'h9;
    localparam logic [3:0] ADDR_INEN   = 4'hb;
    localparam logic [3:0] ADDR_PRS    = 4'hc;
    localparam logic [3:0] ADDR_INCR   = 4'he;

    // ------------------------------------------------------------
    // Channel constants and reset values
    // ------------------------------------------------------------
    localparam int         NUM_CH     = 6;
    localparam int         NUM_PIN_CH = 4;
    localparam int         NUM_INT_CH = 5;
    localparam int         CNT_W      = 13;
    localparam logic [7:0] DUTY_FULL  = 8'hff;
    localparam logic [7:0] DUTY_SUB   = 8'hf7;
    localparam logic [7:0] DUTY_RST   = 8'h00;
    localparam logic [7:0] PH_STEP    = 8'h40;
    localparam logic [8:0] STEP_S     = 9'h004;
    localparam logic [8:0] STEP_M     = 9'h008;
    localparam logic [8:0] STEP_L     = 9'h010;

    typedef struct packed {
        logic       wd;
        logic [1:0] ph;
        logic       on;
        logic [7:0] duty;
    } mpc_chan_word_t;

    typedef struct packed {
        logic en;
        logic use_global;
    } mpc_route_t;

    // Saturating duty step
    function automatic logic [7:0] mpc_sat_step(input logic [7:0] d, input logic up,
                                                input logic [1:0] st);
        logic [8:0] amt;
        logic [8:0] sum;
        amt = (st == 2'b00) ? 9'h000 : (st == 2'b01) ? STEP_S : (st == 2'b10) ? STEP_M : STEP_L;
        sum = up ? ({1'b0, d} + amt) : ({1'b0, d} - amt);
        if (sum[8])
            return up ? DUTY_FULL : DUTY_RST;
        return sum[7:0];
    endfunction : mpc_sat_step

    function automatic logic [7:0] mpc_skip_code(input logic [7:0] code, input logic [2:0] idx);
        logic [2:0] rank;
        logic [7:0] gap;
        rank = {idx[0], idx[1], idx[2]};
        gap  = DUTY_FULL - code;
        if (code > DUTY_SUB && code != DUTY_FULL && {5'h00, rank} < gap)
            return DUTY_SUB;
        return (code > DUTY_SUB) ? DUTY_FULL : code;
    endfunction : mpc_skip_code

endpackage : mpc_pkg

// ---- design/mpc_top.sv ----
// Multichannel PWM controller: SPI frame decode, registers, reference clock
// monitor, shared PWM counter, pin routing and six channel generators.
// Assumes every pin is asynchronous to clk and the reference clock is much slower.
`timescale 1ns/1ps
`default_nettype none
module mpc_top #(
    parameter int REF_FAST_CYC = mpc_pkg::REF_FAST_CYC,
    parameter int REF_SLOW_CYC = mpc_pkg::REF_SLOW_CYC,
    parameter int MON_W        = 12
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Serial port
    input  wire logic       sck,
    input  wire logic       si,
    input  wire logic       chip_select_n,
    output logic            so,
    output logic            so_oe,
    // Reference clock and control pins
    input  wire logic       ref_clk,
    input  wire logic [3:0] in_pin,
    input  wire logic       fail_mode,
    // Results
    output logic [5:0]      output_channels,
    output logic [3:0]      filtered_input,
    output logic            clk_fail
);
    localparam int NCH = mpc_pkg::NUM_CH;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Bits: 0 sck, 1 si, 2 cs, 3 ref, 7:4 pins, 8 fail
    logic [8:0] s1, s2, s3, s4;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1 <= 9'h004;
            s2 <= 9'h004;
            s3 <= 9'h004;
            s4 <= 9'h004;
        end else begin
            s1 <= {fail_mode, in_pin, ref_clk, chip_select_n, si, sck};
            s2 <= s1;
            s3 <= s2;
            s4 <= s3;
        end
    end

    logic sck_rise, sck_fall, cs_fall, cs_rise, tick, fail_s;
    assign sck_rise = s2[0] & ~s3[0];
    assign sck_fall = ~s2[0] & s3[0];
    assign cs_fall  = ~s2[2] & s3[2];
    assign cs_rise  = s2[2] & ~s3[2];
    assign tick     = s2[3] & ~s3[3];
    assign fail_s   = s2[8];

    // ------------------------------------------------------------
    // Serial frame
    // ------------------------------------------------------------
    logic [15:0] shift, next_shift, so_sh, next_so_sh;
    logic [4:0]  bitcnt, next_bitcnt;
    logic        commit;
    logic [3:0]  addr;
    assign commit = cs_rise && (bitcnt == 5'(mpc_pkg::FRAME_BITS));
    assign addr   = shift[15:mpc_pkg::ADDR_LSB];

    always_comb begin
        next_shift  = shift;
        next_so_sh  = so_sh;
        next_bitcnt = bitcnt;
        if (cs_fall) begin
            next_bitcnt = 5'd0;
            next_so_sh  = {3'b000, clk_fail, fail_s, 1'b0, filtered_input, output_channels};
        end else if (!s2[2]) begin
            if (sck_fall) begin
                next_shift  = {shift[14:0], s2[1]};
                next_bitcnt = (bitcnt == 5'h1f) ? bitcnt : bitcnt + 5'd1;
            end
            if (sck_rise)
                next_so_sh = {so_sh[14:0], 1'b0};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift  <= 16'h0000;
            so_sh  <= 16'h0000;
            bitcnt <= 5'd0;
            so     <= 1'b0;
            so_oe  <= 1'b0;
        end else begin
            shift  <= next_shift;
            so_sh  <= next_so_sh;
            bitcnt <= next_bitcnt;
            so     <= next_so_sh[15];
            so_oe  <= ~s2[2];
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    mpc_pkg::mpc_chan_word_t cfg [NCH];
    mpc_pkg::mpc_chan_word_t next_cfg [NCH];
    logic [4:0]  skip_en, next_skip_en;
    logic [5:0]  gsel, next_gsel;
    logic [7:0]  gduty, next_gduty;
    logic [7:0]  ien, next_ien;
    logic [11:0] prs, next_prs;
    logic        sync_req;
    logic [2:0]  ch_idx;
    assign ch_idx   = 3'(addr - mpc_pkg::ADDR_CH_LO);
    assign sync_req = commit && addr == mpc_pkg::ADDR_INIT2 && shift[mpc_pkg::SYNC_BIT];

    always_comb begin
        next_cfg     = cfg;
        next_skip_en = skip_en;
        next_gsel    = gsel;
        next_gduty   = gduty;
        next_ien     = ien;
        next_prs     = prs;
        if (commit) begin
            if (addr >= mpc_pkg::ADDR_CH_LO && addr <= mpc_pkg::ADDR_CH_HI)
                next_cfg[ch_idx] = shift[11:0];
            if (addr == mpc_pkg::ADDR_OUTCTL) begin
                for (int i = 0; i < NCH; i++)
                    next_cfg[i].on = shift[i];
                next_skip_en = shift[mpc_pkg::SKIP_LSB +: mpc_pkg::NUM_INT_CH];
            end
            if (addr == mpc_pkg::ADDR_GLOBAL) begin
                if (shift[mpc_pkg::SUBSEL_BIT])
                    next_gduty = shift[7:0];
                else
                    next_gsel = shift[5:0];
            end
            if (addr == mpc_pkg::ADDR_INEN)
                next_ien = shift[7:0];
            if (addr == mpc_pkg::ADDR_PRS) begin
                if (shift[mpc_pkg::SUBSEL_BIT])
                    next_prs[11:6] = shift[5:0];
                else
                    next_prs[5:0] = shift[5:0];
            end
            // channels one to five, step sizes, saturation
            if (addr == mpc_pkg::ADDR_INCR) begin
                for (int i = 0; i < mpc_pkg::NUM_INT_CH; i++)
                    next_cfg[i].duty = mpc_pkg::mpc_sat_step(cfg[i].duty,
                                         shift[mpc_pkg::SIGN_BIT], shift[2*i +: 2]);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NCH; i++)
                cfg[i] <= '0;
            skip_en <= 5'h00;
            gsel    <= 6'h00;
            gduty   <= mpc_pkg::DUTY_RST;
            ien     <= 8'h00;
            prs     <= 12'h000;
        end else begin
            cfg     <= next_cfg;
            skip_en <= next_skip_en;
            gsel    <= next_gsel;
            gduty   <= next_gduty;
            ien     <= next_ien;
            prs     <= next_prs;
        end
    end

    // ------------------------------------------------------------
    // Reference clock monitor and shared counter
    // ------------------------------------------------------------
    logic [MON_W-1:0]            percnt, next_percnt;
    logic                        next_clk_fail;
    logic [mpc_pkg::CNT_W-1:0]   cnt, next_cnt;
    logic                        start_src, next_start_src;

    always_comb begin
        next_percnt   = tick ? '0 : ((percnt == '1) ? percnt : percnt + 1'b1);
        next_clk_fail = clk_fail;
        if (tick)
            next_clk_fail = (percnt < MON_W'(REF_FAST_CYC));
        else if (percnt >= MON_W'(REF_SLOW_CYC))
            next_clk_fail = 1'b1;
        next_cnt       = sync_req ? '0 : (tick ? cnt + 1'b1 : cnt);
        next_start_src = tick | sync_req;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            percnt    <= '0;
            clk_fail  <= 1'b1;
            cnt       <= '0;
            start_src <= 1'b0;
        end else begin
            percnt    <= next_percnt;
            clk_fail  <= next_clk_fail;
            cnt       <= next_cnt;
            start_src <= next_start_src;
        end
    end

    // ------------------------------------------------------------
    // Deglitched pins
    // ------------------------------------------------------------
    logic [3:0] next_filtered;
    always_comb begin
        for (int i = 0; i < mpc_pkg::NUM_PIN_CH; i++)
            next_filtered[i] = (s2[4+i] == s3[4+i] && s3[4+i] == s4[4+i]) ? s3[4+i]
                                                                           : filtered_input[i];
    end

    // ------------------------------------------------------------
    // Routing and channels
    // ------------------------------------------------------------
    // pin enable table, source select
    function automatic mpc_pkg::mpc_route_t route_f(input logic on, input logic [1:0] en,
                                                    input logic pin, input logic gs);
        mpc_pkg::mpc_route_t r;
        r.en         = on && (en == 2'b00 || en == 2'b11 || pin);
        r.use_global = (en == 2'b11 && pin) ? ~gs : gs;
        return r;
    endfunction : route_f

    logic [5:0] pwm, chan_en, skip_all;
    assign skip_all = {1'b0, skip_en};
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_ch
            mpc_pkg::mpc_route_t rt;
            logic [1:0] pr;
            logic [9:0] wide;
            logic [7:0] pos;
            logic [2:0] idx;
            logic       sub0;
            logic [7:0] tgt;
            assign pr = prs[2*g +: 2];
            assign wide = pr[1] ? {2'b00, cnt[7:0]} : pr[0] ? {1'b0, cnt[8:0]} : cnt[9:0];
            assign idx  = pr[1] ? cnt[10:8] : pr[0] ? cnt[11:9] : cnt[12:10];
            assign sub0 = pr[1] ? 1'b1 : pr[0] ? ~wide[0] : (wide[1:0] == 2'b00);
            // own phase even on shared duty
            assign pos  = 8'((pr[1] ? wide[7:0] : pr[0] ? wide[8:1] : wide[9:2])
                             + 8'(cfg[g].ph * mpc_pkg::PH_STEP));
            // pin following for channels with pins
            if (g < mpc_pkg::NUM_PIN_CH) begin : gen_pin
                assign rt = route_f(cfg[g].on, ien[2*g +: 2], filtered_input[g], gsel[g]);
            end else begin : gen_nopin
                assign rt = route_f(cfg[g].on, 2'b00, 1'b0, gsel[g]);
            end
            assign tgt        = rt.use_global ? gduty : cfg[g].duty;
            assign chan_en[g] = rt.en;
            mpc_chan_pwm u_ch (
                .clk       (clk),
                .rst       (rst),
                .enable    (rt.en),
                .target    (tgt),
                .skip_en   (skip_all[g]),
                .frame_idx (idx),
                .pos       (pos),
                .start     (start_src && pos == 8'h00 && sub0),
                .pwm_out   (pwm[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------
    logic [5:0] next_out;
    always_comb begin
        // no PWM in fail mode or clock fail
        if (fail_s)
            next_out = {2'b00, filtered_input};
        else if (clk_fail)
            next_out = chan_en;
        else
            next_out = pwm;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            output_channels <= 6'h00;
            filtered_input  <= 4'h0;
        end else begin
            output_channels <= next_out;
            filtered_input  <= next_filtered;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [7:0] duty0, duty5;
    logic [5:0] on_vec;
    assign duty0 = cfg[0].duty;
    assign duty5 = cfg[5].duty;
    always_comb begin
        for (int i = 0; i < NCH; i++)
            on_vec[i] = cfg[i].on;
    end

    property p_clk_fail_full;
        @(posedge clk) disable iff (rst)
        (clk_fail && !fail_s) |=> output_channels == $past(chan_en);
    endproperty
    a_clk_fail_full: assert property (p_clk_fail_full) else $error("no full duty");

    property p_fail_mode;
        @(posedge clk) disable iff (rst)
        fail_s |=> (output_channels[5:4] == 2'b00 && output_channels[3:0] == $past(filtered_input));
    endproperty
    a_fail_mode: assert property (p_fail_mode) else $error("fail mode output wrong");

    property p_sync;
        @(posedge clk) disable iff (rst)
        sync_req |=> cnt == '0;
    endproperty
    a_sync: assert property (p_sync) else $error("counter not reset");

    property p_word;
        @(posedge clk) disable iff (rst)
        (commit && addr == 4'h2) |=> duty0 == $past(shift[7:0]);
    endproperty
    a_word: assert property (p_word) else $error("channel word lost");

    property p_onbits;
        @(posedge clk) disable iff (rst)
        (commit && addr == 4'h8) |=> on_vec == $past(shift[5:0]);
    endproperty
    a_onbits: assert property (p_onbits) else $error("on bits not written");

    property p_step4;
        @(posedge clk) disable iff (rst)
        (commit && addr == 4'he && shift[10] && shift[1:0] == 2'b01 && duty0 < 8'hf0)
            |=> duty0 == 8'($past(duty0) + 8'h04);
    endproperty
    a_step4: assert property (p_step4) else $error("step of four wrong");

    property p_sat;
        @(posedge clk) disable iff (rst)
        (commit && addr == 4'he && !shift[10] && duty0 < 8'h10 && shift[1:0] == 2'b11)
            |=> duty0 == 8'h00;
    endproperty
    a_sat: assert property (p_sat) else $error("no floor saturation");

    property p_sixth_fixed;
        @(posedge clk) disable iff (rst)
        (commit && addr == 4'he) |=> (duty5 == $past(duty5) && gduty == $past(gduty));
    endproperty
    a_sixth_fixed: assert property (p_sixth_fixed) else $error("step touched ch6");

endmodule : mpc_top
`default_nettype wire

// ---- tb/mpc_spi_host.sv ----
// SPI master standing in for the controller.
// Assumes clk is the bench's 25 MHz clock; frames start on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module mpc_spi_host (
    // Bench clock
    input  wire logic clk,
    // Serial port
    input  wire logic so,
    input  wire logic so_oe,
    output logic      sck,
    output logic      si,
    output logic      chip_select_n
);
    // Status word seen on so, and so_oe held through the frame
    logic [15:0] rx      = 16'h0000;
    logic        oe_seen = 1'b0;
    initial begin
        sck = 1'b0;
        si = 1'b0;
        chip_select_n = 1'b1;
    end
    task automatic send(input logic [15:0] w);
        @(negedge clk);
        chip_select_n = 1'b0;
        oe_seen = 1'b1;
        for (int i = 15; i >= 0; i--) begin
            #200 rx = {rx[14:0], so};
            oe_seen = oe_seen & so_oe;
            sck = 1'b1;
            si = w[i];
            #200 sck = 1'b0;
        end
        #200 chip_select_n = 1'b1;
        // Released line shows no stale bit
        si = ~si;
        #400;
    endtask : send
endmodule : mpc_spi_host
`default_nettype wire

// ---- tb/test_multichannel_pwm_control.sv ----
// Self-checking bench for the PWM controller top.
// Assumes the SPI host model and a 320 ns reference clock.
`timescale 1ns/1ps
`default_nettype none
module test_multichannel_pwm_control;
    logic        clk = 1'b0, rst = 1'b1, ref_clk = 1'b0, ref_run = 1'b0;
    logic        fail_mode = 1'b0, clr = 1'b0, sub;
    logic        sck, si, chip_select_n, so, so_oe, clk_fail;
    logic [3:0]  in_pin = 4'h0, filtered_input;
    logic [5:0]  output_channels;
    logic [7:0]  dd;
    logic [14:0] hcnt = 15'h0000, lrun = 15'h0000, lmax = 15'h0000;
    logic [16:0] q[$], e;
    int          n_fail = 0, compares = 0;
    event        look;
    always #20 clk = ~clk;
    // reference clock, 8 clk per step
    always #160 ref_clk = ref_run & ~ref_clk;
    mpc_spi_host host_u (.clk(clk), .so(so), .so_oe(so_oe), .sck(sck), .si(si),
        .chip_select_n(chip_select_n));
    mpc_top #(.REF_FAST_CYC(4), .REF_SLOW_CYC(32)) dut_u (.clk(clk), .rst(rst), .sck(sck),
        .si(si), .chip_select_n(chip_select_n), .so(so), .so_oe(so_oe), .ref_clk(ref_clk),
        .in_pin(in_pin), .fail_mode(fail_mode), .output_channels(output_channels),
        .filtered_input(filtered_input), .clk_fail(clk_fail));
    // High time and longest low run of channel one
    always @(posedge clk) begin
        hcnt <= clr ? 15'h0000 : hcnt + 15'(output_channels[0]);
        lrun <= (clr | output_channels[0]) ? 15'h0000 : lrun + 15'h0001;
        lmax <= clr ? 15'h0000 : (lrun > lmax) ? lrun : lmax;
    end
    task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    always @(look) begin
        while (q.size() > 0) begin
            e = q.pop_front();
            chk((e[16:15] == 2'b11) ? {so_oe, host_u.oe_seen, host_u.rx[12:0]}
                : e[16] ? lmax : e[15] ? hcnt
                : {4'h0, filtered_input, clk_fail, output_channels}, e[14:0]);
        end
    end
    task automatic note(input logic [16:0] x);
        q.push_back(x);
        ->look;
    endtask : note
    task automatic results;
        $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results
    initial begin
        #4_000_000;
        n_fail++;
        results();
    end
    initial begin
        void'($urandom(32'h1506));
        repeat (16) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        ref_run = 1'b1;
        note(17'h00040);
        repeat (64) @(negedge clk);
        // ch1 still off, divide by 1
        host_u.send({4'hc, 12'h002});
        host_u.send({4'h1, 12'h002});
        host_u.send({4'h2, 12'h1ff});
        note(17'h00001);
        host_u.send({4'h8, 12'h000});
        note(17'h00000);
        note({2'b11, 2'b01, 13'h0001});
        $display("test switching done");
        for (int i = 0; i < 4; i++) begin
            dd = (i == 0) ? 8'hfe : (i == 1) ? 8'hfa : (i == 2) ? 8'($urandom_range(7)) : 8'h04;
            if (i < 3) begin
                host_u.send({4'h2, 4'h1, dd});
            end else begin
                host_u.send({4'he, 12'h003});
                host_u.send({4'he, 12'h401});
            end
            host_u.send({4'h8, 12'h041});
            repeat (2048) @(negedge clk);
            clr = 1'b1;
            @(negedge clk) clr = 1'b0;
            repeat (16384) @(negedge clk);
            sub = (dd > 8'hf7) && (dd != 8'hff);
            note({2'b01, 15'(dd + 8'h01) << 6});
            note({2'b10, sub ? 15'h0040 : 15'(8'hff - dd) << 3});
            $display("test duty case %0d done", i);
        end
        host_u.send({4'h9, 12'h8ff});
        host_u.send({4'h9, 12'h001});
        @(negedge clk) clr = 1'b1;
        @(negedge clk) clr = 1'b0;
        repeat (64) @(negedge clk);
        note({2'b01, 15'h0040});
        host_u.send({4'hb, 12'h001});
        note({2'b00, 15'h0000});
        host_u.send({4'h8, 12'h040});
        host_u.send({4'hc, 12'h001});
        in_pin = 4'h1;
        host_u.send({4'hb, 12'h003});
        host_u.send({4'h8, 12'h041});
        repeat (4096) @(negedge clk);
        @(negedge clk) clr = 1'b1;
        @(negedge clk) clr = 1'b0;
        repeat (4096) @(negedge clk);
        note({2'b01, 15'h0050});
        $display("test routing done");
        fail_mode = 1'b1;
        in_pin = 4'($urandom);
        repeat (30) @(negedge clk);
        note({6'h00, in_pin, 3'b000, in_pin});
        fail_mode = 1'b0;
        ref_run = 1'b0;
        repeat (80) @(negedge clk);
        note({6'h00, in_pin, 7'h41});
        @(negedge clk) $display("test fail cases done");
        results();
    end
endmodule : test_multichannel_pwm_control
`default_nettype wire
